//--- hw/icache_fetch.sv
// Instruction cache with two fill buffers and an AXI4-Lite control slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module icache_fetch #(
  parameter int SETS = 32
) (
  input  wire logic        aclk,            // Core clock, 25 MHz
  input  wire logic        aresetn,         // Synchronous reset, active low
  input  wire logic [7:0]  awaddr,          // Write address
  input  wire logic        awvalid,         // Write address valid
  output logic             awready,         // Write address ready
  input  wire logic [31:0] wdata,           // Write data
  input  wire logic [3:0]  wstrb,           // Write byte strobes
  input  wire logic        wvalid,          // Write data valid
  output logic             wready,          // Write data ready
  output logic [1:0]       bresp,           // Write response
  output logic             bvalid,          // Write response valid
  input  wire logic        bready,          // Write response ready
  input  wire logic [7:0]  araddr,          // Read address
  input  wire logic        arvalid,         // Read address valid
  output logic             arready,         // Read address ready
  output logic [31:0]      rdata,           // Read data
  output logic [1:0]       rresp,           // Read response
  output logic             rvalid,          // Read data valid
  input  wire logic        rready,          // Read data ready
  input  wire logic        req_valid,       // Fetch request
  input  wire logic [31:0] req_addr,        // Virtual fetch address
  output logic             req_ready,       // Request served this cycle
  input  wire logic        mmu_on,          // Translation enabled
  input  wire logic        page_cacheable,  // Page cacheable attribute
  output logic             resp_valid,      // Instruction returned
  output logic [31:0]      resp_instr,      // Returned instruction
  output logic             resp_parity_err, // Word failed parity
  input  wire logic        exec_parity_err, // Errored word reaches execute
  output logic             prefetch_abort,  // Abort pulse to the core
  output logic             fill_req_valid,  // Line fetch request
  input  wire logic        fill_req_ready,  // Bus takes the request
  output logic [31:0]      fill_req_addr,   // Aligned line address
  output logic             fill_req_id,     // Buffer the line fills
  input  wire logic        fill_valid,      // One fill word arrives
  input  wire logic        fill_id,         // Buffer of that word
  input  wire logic [2:0]  fill_word,       // Word index in line
  input  wire logic [31:0] fill_data        // Fill word
);

  localparam int SET_W = $clog2(SETS);
  localparam int TAG_W = 27 - SET_W;

  // Only the two documented sizes are built
  if (SETS != 32 && SETS != 16) begin : g_bad_sets
    $error("SETS must be 16 or 32");
  end

  function automatic logic par_of(input logic [31:0] d);
    par_of = ^d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [icache_pkg::WAYS-1:0] lvalid_reg [SETS];
  logic [TAG_W-1:0]            tag_reg    [SETS][icache_pkg::WAYS];
  logic [32:0]                 word_reg   [SETS][icache_pkg::WAYS][icache_pkg::WORDS];
  logic [4:0]                  rr_reg     [SETS];
  logic [4:0]                  lock_reg   [SETS];

  logic [1:0]  busy_reg;
  logic [1:0]  issued_reg;
  logic [1:0]  kill_reg;
  logic [1:0]  cach_reg;
  logic [26:0] baddr_reg [2];
  logic [7:0]  bvld_reg  [2];
  logic [31:0] bdat_reg  [2][icache_pkg::WORDS];

  logic        en_reg;
  logic        fault_reg;
  logic [31:0] faddr_reg;
  logic [31:0] errpc_reg;
  logic        abort_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Address split: virtual index and virtual tag, no translation
  logic [2:0]       req_word;
  logic [SET_W-1:0] req_set;
  logic [TAG_W-1:0] req_tag;
  logic [26:0]      req_line;
  assign req_word = req_addr[4:2];
  assign req_set  = req_addr[5 +: SET_W];
  assign req_tag  = req_addr[31 -: TAG_W];
  assign req_line = req_addr[31:5];

  // Array lookup runs whether enabled or not
  logic        arr_hit;
  logic [4:0]  hit_way;
  always_comb begin
    arr_hit = 1'b0;
    hit_way = 5'h00;
    for (int w = 0; w < icache_pkg::WAYS; w++) begin
      if (!arr_hit && lvalid_reg[req_set][w] && tag_reg[req_set][w] == req_tag) begin
        arr_hit = 1'b1;
        hit_way = 5'(w);
      end
    end
  end

  logic [32:0] arr_word;
  logic        par_bad;
  assign arr_word = word_reg[req_set][hit_way][req_word];
  assign par_bad  = ^arr_word;

  // Fetch buffer match; killed buffers are invisible
  logic [1:0]  bline;
  logic [1:0]  bhit;
  logic        buf_hit;
  logic [31:0] buf_word;
  assign bline[0] = busy_reg[0] & ~kill_reg[0] & (baddr_reg[0] == req_line);
  assign bline[1] = busy_reg[1] & ~kill_reg[1] & (baddr_reg[1] == req_line);
  assign bhit[0]  = bline[0] & bvld_reg[0][req_word];
  assign bhit[1]  = bline[1] & bvld_reg[1][req_word];
  assign buf_hit  = |bhit;
  assign buf_word = bhit[0] ? bdat_reg[0][req_word] : bdat_reg[1][req_word];

  // A word still in flight stalls until it lands in its buffer
  assign req_ready = arr_hit | buf_hit;

  // Allocation of a buffer on a true miss
  logic [1:0] free_b;
  logic       need_alloc;
  logic       alloc;
  logic       alloc_id;
  assign free_b     = ~busy_reg;
  assign need_alloc = req_valid & ~arr_hit & ~(|bline);
  assign alloc      = need_alloc & (|free_b);
  assign alloc_id   = ~free_b[0];

  // Completion: at most one fill word per cycle, so one line at a time
  logic [1:0]       done;
  logic             any_done;
  logic             done_id;
  logic             do_fill;
  logic [SET_W-1:0] wset;
  logic [4:0]       wway;
  logic [4:0]       rr_next;
  assign done[0]  = busy_reg[0] & (bvld_reg[0] == icache_pkg::LINE_FULL);
  assign done[1]  = busy_reg[1] & (bvld_reg[1] == icache_pkg::LINE_FULL);
  assign any_done = |done;
  assign done_id  = ~done[0];
  assign do_fill  = any_done & cach_reg[done_id] & en_reg & ~kill_reg[done_id];
  assign wset     = baddr_reg[done_id][SET_W-1:0];
  assign wway     = rr_reg[wset];
  assign rr_next  = (wway == icache_pkg::LAST_WAY) ? lock_reg[wset] : wway + 5'h01;

  // Fill request goes out for the lowest-numbered unissued buffer, buffer 0 first
  logic [1:0] pend;
  logic       pend_id;
  logic [1:0] sent_b;
  assign pend           = busy_reg & ~issued_reg;
  assign pend_id        = ~pend[0];
  assign sent_b = issued_reg | ({2{fill_req_valid & fill_req_ready}} & {pend_id, ~pend_id});
  assign fill_req_valid = |pend;
  assign fill_req_id    = pend_id;
  assign fill_req_addr  = {baddr_reg[pend_id], 5'h00};

  //////////////////////////////////////////////////////////////////////////////
  // Register slave decode
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  logic do_wr;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_lock;
  logic wr_fault;
  logic wr_hit;
  logic inv;
  assign do_wr    = aw_hold & w_hold & ~bvalid_reg;
  assign wr_ctrl  = do_wr & (awaddr_reg == icache_pkg::OFS_CTRL);
  assign wr_cmd   = do_wr & (awaddr_reg == icache_pkg::OFS_CMD);
  assign wr_lock  = do_wr & (awaddr_reg == icache_pkg::OFS_LOCK) & wstrb_reg[0] & wstrb_reg[1];
  assign wr_fault = do_wr & (awaddr_reg == icache_pkg::OFS_FAULT) & wstrb_reg[0];
  assign wr_hit   = (awaddr_reg == icache_pkg::OFS_CTRL) | (awaddr_reg == icache_pkg::OFS_CMD) |
                    (awaddr_reg == icache_pkg::OFS_LOCK) | (awaddr_reg == icache_pkg::OFS_FAULT);
  assign inv      = wr_cmd & wstrb_reg[0] & wdata_reg[icache_pkg::CMD_INV_BIT];

  logic [SET_W-1:0] lk_set;
  logic [4:0]       lk_cnt;
  assign lk_set = wdata_reg[icache_pkg::LOCK_SET_LSB +: SET_W];
  assign lk_cnt = (wdata_reg[4:0] > icache_pkg::MAX_LOCK) ? icache_pkg::MAX_LOCK : wdata_reg[4:0];

  logic        rd_ok;
  logic [31:0] rd_mux;
  assign rd_ok  = (araddr == icache_pkg::OFS_CTRL) | (araddr == icache_pkg::OFS_CMD) |
                  (araddr == icache_pkg::OFS_LOCK) | (araddr == icache_pkg::OFS_FAULT) |
                  (araddr == icache_pkg::OFS_FADDR) | (araddr == icache_pkg::OFS_STAT);
  assign rd_mux = (araddr == icache_pkg::OFS_CTRL)  ? 32'(en_reg) << icache_pkg::CTRL_EN_BIT :
                  (araddr == icache_pkg::OFS_FAULT) ? 32'(fault_reg) :
                  (araddr == icache_pkg::OFS_FADDR) ? faddr_reg :
                  (araddr == icache_pkg::OFS_STAT)  ? {28'h000_0000, kill_reg, busy_reg} :
                  32'h0000_0000;

  assign awready = ~aw_hold & ~bvalid_reg;
  assign wready  = ~w_hold & ~bvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = ~rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  // Write path: address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold    <= 1'b0;
      w_hold     <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= icache_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold    <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold    <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_wr) begin
        aw_hold    <= 1'b0;
        w_hold     <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? icache_pkg::RESP_OKAY : icache_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read path answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= icache_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? icache_pkg::RESP_OKAY : icache_pkg::RESP_SLVERR;
      rdata_reg  <= rd_ok ? rd_mux : 32'h0000_0000;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, fault recording and abort
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg    <= icache_pkg::EN_RESET;
      fault_reg <= 1'b0;
      faddr_reg <= 32'h0000_0000;
      errpc_reg <= 32'h0000_0000;
      abort_reg <= 1'b0;
    end else begin
      if (wr_ctrl && wstrb_reg[1]) begin
        en_reg <= wdata_reg[icache_pkg::CTRL_EN_BIT];
      end
      if (req_valid && arr_hit && par_bad) begin
        errpc_reg <= req_addr;
      end
      // Set wins over a software clear in the same cycle
      if (exec_parity_err) begin
        fault_reg <= 1'b1;
        faddr_reg <= errpc_reg;
      end else if (wr_fault && wdata_reg[icache_pkg::FAULT_PAR_BIT]) begin
        fault_reg <= 1'b0;
      end
      abort_reg <= exec_parity_err;
    end
  end
  assign prefetch_abort = abort_reg;

  // Response registers; parity is only judged for array reads
  logic        rsp_v_reg;
  logic [31:0] rsp_i_reg;
  logic        rsp_e_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_v_reg <= 1'b0;
      rsp_i_reg <= 32'h0000_0000;
      rsp_e_reg <= 1'b0;
    end else begin
      rsp_v_reg <= req_valid & req_ready;
      rsp_i_reg <= arr_hit ? arr_word[31:0] : buf_word;
      rsp_e_reg <= req_valid & arr_hit & par_bad;
    end
  end
  assign resp_valid      = rsp_v_reg;
  assign resp_instr      = rsp_i_reg;
  assign resp_parity_err = rsp_e_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Fetch buffers; invalidate kills issued fills so late words are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg   <= 2'h0;
      issued_reg <= 2'h0;
      kill_reg   <= 2'h0;
      cach_reg   <= 2'h0;
      baddr_reg  <= '{default: 27'h000_0000};
      bvld_reg   <= '{default: 8'h00};
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (fill_valid && fill_id == 1'(b) && busy_reg[b]) begin
          bvld_reg[b][fill_word]  <= 1'b1;
          bdat_reg[b][fill_word]  <= fill_data;
        end
        if (fill_req_valid && fill_req_ready && pend_id == 1'(b)) begin
          issued_reg[b] <= 1'b1;
        end
        if (any_done && done_id == 1'(b)) begin
          busy_reg[b]   <= 1'b0;
          issued_reg[b] <= 1'b0;
          kill_reg[b]   <= 1'b0;
          bvld_reg[b]   <= 8'h00;
        end else if (inv && busy_reg[b]) begin
          // Unissued buffers free at once; a request taken this edge must drain
          busy_reg[b] <= sent_b[b];
          kill_reg[b] <= sent_b[b];
          if (!sent_b[b]) begin
            bvld_reg[b] <= 8'h00;
          end
        end
        if (alloc && alloc_id == 1'(b)) begin
          busy_reg[b]   <= 1'b1;
          issued_reg[b] <= 1'b0;
          kill_reg[b]   <= 1'b0;
          baddr_reg[b]  <= req_line;
          bvld_reg[b]   <= 8'h00;
          cach_reg[b]   <= ~mmu_on | page_cacheable;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array state: nothing outside this block writes it, so no snooping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < SETS; s++) begin
        lvalid_reg[s] <= '0;
        rr_reg[s]     <= icache_pkg::RR_RESET;
        lock_reg[s]   <= 5'h00;
      end
    end else begin
      if (inv) begin
        for (int s = 0; s < SETS; s++) begin
          for (int w = 0; w < icache_pkg::WAYS; w++) begin
            if (5'(w) >= lock_reg[s]) begin
              lvalid_reg[s][w] <= 1'b0;
            end
          end
        end
      end
      if (wr_lock) begin
        lock_reg[lk_set] <= lk_cnt;
        rr_reg[lk_set]   <= icache_pkg::RR_RESET;
      end
      if (do_fill) begin
        lvalid_reg[wset][wway] <= 1'b1;
        tag_reg[wset][wway]    <= baddr_reg[done_id][26 -: TAG_W];
        rr_reg[wset]           <= rr_next;
      end
    end
  end

  // Line data with parity generated on the way into the array
  always_ff @(posedge aclk) begin
    if (do_fill) begin
      for (int i = 0; i < icache_pkg::WORDS; i++) begin
        word_reg[wset][wway][i] <= {par_of(bdat_reg[done_id][i]),
                                    bdat_reg[done_id][i]};
      end
    end
  end

endmodule

//--- hw/icache_pkg.sv
// Constants shared by the instruction cache fetch unit and its bench
package icache_pkg;

  localparam int WAYS   = 32;
  localparam int WORDS  = 8;
  localparam int WAY_W  = 5;
  localparam int WORD_W = 3;
  localparam int LINE_W = 27;

  localparam logic [4:0] RR_RESET  = 5'h1f;
  localparam logic [4:0] LAST_WAY  = 5'h1f;
  localparam logic [4:0] MAX_LOCK  = 5'h1c;
  localparam logic [7:0] LINE_FULL = 8'hff;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_LOCK  = 8'h08;
  localparam logic [7:0] OFS_FAULT = 8'h0c;
  localparam logic [7:0] OFS_FADDR = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Field positions
  localparam int CTRL_EN_BIT   = 12;
  localparam int CMD_INV_BIT   = 0;
  localparam int LOCK_SET_LSB  = 8;
  localparam int FAULT_PAR_BIT = 0;

  localparam logic       EN_RESET   = 1'b0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- test/fill_bus_model.sv
// External bus model answering line fetches one word at a time
`timescale 1ns/100ps
module fill_bus_model (
  input  wire logic        aclk,           // Clock
  input  wire logic        slow,           // Gap after each word
  input  wire logic        fill_req_valid, // Line request
  input  wire logic [31:0] fill_req_addr,  // Line address
  input  wire logic        fill_req_id,    // Buffer id
  output logic             fill_req_ready, // Request taken
  output logic             fill_valid,     // Word strobe
  output logic             fill_id,        // Word buffer
  output logic [2:0]       fill_word,      // Word index
  output logic [31:0]      fill_data,      // Word
  output int               fill_count      // Lines served
);
  logic [31:0] line;
  // One line at a time, so a second miss waits in its buffer
  initial begin
    fill_req_ready = 1'b0;
    fill_valid = 1'b0;
    fill_id = 1'b0;
    fill_word = 3'h0;
    fill_data = 32'h0000_0000;
    fill_count = 0;
    forever begin
      @(posedge aclk);
      if (fill_req_valid) begin
        fill_req_ready <= 1'b1;
        @(posedge aclk);
        line = fill_req_addr;
        fill_id <= fill_req_id;
        fill_req_ready <= 1'b0;
        fill_count <= fill_count + 1;
        // Never faster than one word a cycle; idle lines show garbage
        for (int w = 0; w < 8; w++) begin
          @(posedge aclk);
          fill_valid <= 1'b1;
          fill_word <= w[2:0];
          fill_data <= {line[31:5], w[2:0], 2'b00} ^ 32'hc3a5_0f96;
          if (slow) begin
            @(posedge aclk);
            fill_valid <= 1'b0;
            fill_data <= ~fill_data;
          end
        end
        @(posedge aclk);
        fill_valid <= 1'b0;
        fill_word <= ~fill_word;
        fill_data <= ~fill_data;
      end
    end
  end
endmodule

//--- test/icache_fetch_properties.sv
// Port-level checks for the instruction cache fetch unit
`timescale 1ns/100ps
module icache_fetch_properties (
  input wire logic        aclk,            // Clock
  input wire logic        aresetn,         // Reset, low
  input wire logic        awvalid,         // AW valid
  input wire logic        awready,         // AW ready
  input wire logic        wvalid,          // W valid
  input wire logic        wready,          // W ready
  input wire logic        bvalid,          // B valid
  input wire logic        arvalid,         // AR valid
  input wire logic        arready,         // AR ready
  input wire logic [31:0] rdata,           // R data
  input wire logic        rvalid,          // R valid
  input wire logic        rready,          // R ready
  input wire logic        req_valid,       // Fetch request
  input wire logic        req_ready,       // Fetch served
  input wire logic        resp_valid,      // Word out
  input wire logic        resp_parity_err, // Parity flag
  input wire logic        exec_parity_err, // Bad word executed
  input wire logic        prefetch_abort,  // Abort pulse
  input wire logic        fill_req_valid,  // Line request
  input wire logic        fill_req_ready,  // Bus takes it
  input wire logic [31:0] fill_req_addr,   // Line address
  input wire logic        fill_req_id      // Buffer id
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Transfers taken on the two request ports
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_fetch_taken;
    req_valid && req_ready;
  endsequence
  property p_fetch_answer;
    s_fetch_taken |=> resp_valid;
  endproperty
  a_fetch_answer: assert property (p_fetch_answer) else $error("fetch not answered");
  property p_answer_cause;
    resp_valid |-> $past(req_valid && req_ready);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without request");
  property p_fill_aligned;
    fill_req_valid |-> fill_req_addr[4:0] == 5'h00;
  endproperty
  a_fill_aligned: assert property (p_fill_aligned) else $error("line address unaligned");
  // A line request may not move while the bus has not taken it
  property p_fill_hold;
    fill_req_valid && !fill_req_ready |=> fill_req_valid && $stable(fill_req_addr) && $stable(fill_req_id);
  endproperty
  a_fill_hold: assert property (p_fill_hold) else $error("line request dropped");
  property p_parity_flag;
    resp_parity_err |-> resp_valid;
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("stray parity flag");
  property p_abort;
    exec_parity_err |=> prefetch_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missing");
  property p_write_answer;
    s_wr_taken |-> ##[1:2] bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_read_answer;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
endmodule
bind icache_fetch icache_fetch_properties icache_fetch_properties_i (.*);

//--- test/instruction_cache_fetch_unit_test.sv
// Self-checking bench for the instruction cache fetch unit
`timescale 1ns/100ps
module instruction_cache_fetch_unit_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid;
  logic        mmu_on, page_cacheable, exec_parity_err, slow, awready, wready, bvalid;
  logic        arready, rvalid, req_ready, resp_valid, resp_parity_err, prefetch_abort;
  logic        fill_req_valid, fill_req_id, fill_req_ready, fill_valid, fill_id;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  fill_word;
  logic [31:0] wdata, rdata, req_addr, resp_instr, fill_req_addr, fill_data, lfsr_state;
  logic [31:0] exp_instr[$];
  logic [33:0] exp_read[$];
  int          mismatches, samples_checked, n, f, fill_count;
  icache_fetch icache_fetch_i (.*);
  fill_bus_model fill_bus_model_i (.*);
  ////////////////////////////////////////
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'hc3a5_0f96;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Write offers address and data together, drops each once taken
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    check("bresp", {31'h0, bvalid, bresp}, {31'h0, 1'b1, r});
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [33:0] e);
    exp_read.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Request stays up so hits can follow back to back
  task automatic fetch(input logic [31:0] a);
    req_valid <= 1'b1;
    req_addr <= a;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!req_ready && n < 300);
    exp_instr.push_back(mem_word(a));
  endtask
  task automatic idle(input int c);
    req_valid <= 1'b0;
    repeat (c) @(posedge aclk);
  endtask
  ////////////////////////////////////////
  // Answers are matched against the oldest note
  always @(posedge aclk) begin
    if (resp_valid === 1'b1) check("instr", {1'b0, resp_parity_err, resp_instr}, {2'b00, exp_instr.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1) check("rdata", {rresp, rdata}, exp_read.pop_front());
  end
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Runs take about 1000 cycles; allow thirty times that
  initial begin
    #(40 * 30000);
    mismatches++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, slow} = 8'h00;
    {mmu_on, page_cacheable, exec_parity_err} = 3'h0;
    {awaddr, araddr, wstrb, wdata, req_addr} = 84'h0;
    wstrb = 4'hf;
    lfsr_state = 32'h0000_002f;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_read(icache_pkg::OFS_CTRL, {icache_pkg::RESP_OKAY, 32'h0000_0000});
    reg_read(icache_pkg::OFS_STAT, {icache_pkg::RESP_OKAY, 32'h0000_0000});
    reg_read(8'h40, {icache_pkg::RESP_SLVERR, 32'h0000_0000});
    reg_write(8'h40, 32'h0000_0001, icache_pkg::RESP_SLVERR);
    // Executed bad word: abort pulse, sticky fault, cleared by writing one
    exec_parity_err <= 1'b1;
    @(posedge aclk);
    exec_parity_err <= 1'b0;
    @(posedge aclk);
    check("abort", 34'(prefetch_abort), 34'h1);
    reg_read(icache_pkg::OFS_FAULT, {icache_pkg::RESP_OKAY, 32'h0000_0001});
    reg_write(icache_pkg::OFS_FAULT, 32'h0000_0001, icache_pkg::RESP_OKAY);
    reg_read(icache_pkg::OFS_FAULT, {icache_pkg::RESP_OKAY, 32'h0000_0000});
    $display("test registers done");
    // Disabled: buffer hits fetch nothing, lines are never kept
    fetch(32'h0000_1000);
    fetch(32'h0000_1004);
    fetch(32'h0000_1000);
    fetch(32'h0000_101c);
    idle(20);
    check("fills", 34'(fill_count), 34'h1);
    fetch(32'h0000_1000);
    fetch(32'h0000_2000);
    fetch(32'h0000_3000);
    idle(40);
    check("fills", 34'(fill_count), 34'h4);
    $display("test disabled done");
    reg_write(icache_pkg::OFS_CTRL, 32'h0000_1000, icache_pkg::RESP_OKAY);
    reg_read(icache_pkg::OFS_CTRL, {icache_pkg::RESP_OKAY, 32'h0000_1000});
    slow <= 1'b1;
    fetch(32'h0000_5008);
    idle(30);
    fetch(32'h0000_5000);
    fetch(32'h0000_501c);
    {mmu_on, page_cacheable} <= 2'b10;
    fetch(32'h0000_6000);
    idle(30);
    fetch(32'h0000_6000);
    idle(30);
    check("fills", 34'(fill_count), 34'h7);
    page_cacheable <= 1'b1;
    fetch(32'h0000_7000);
    idle(30);
    fetch(32'h0000_7004);
    idle(2);
    check("fills", 34'(fill_count), 34'h8);
    reg_write(icache_pkg::OFS_CMD, 32'h0000_0001, icache_pkg::RESP_OKAY);
    fetch(32'h0000_5000);
    idle(30);
    check("fills", 34'(fill_count), 34'h9);
    $display("test enabled done");
    // Set 1 from reset: 33 lines, the last one evicts way 31 again
    {mmu_on, slow} <= 2'b00;
    f = fill_count;
    for (int k = 0; k < 33; k++) begin
      fetch(32'h0010_0020 + 32'(k) * 32'h0000_0400);
    end
    idle(20);
    fetch(32'h0010_0420);
    idle(2);
    check("fills", 34'(fill_count), 34'(f + 33));
    fetch(32'h0010_0020);
    idle(20);
    check("fills", 34'(fill_count), 34'(f + 34));
    $display("test replacement done");
    for (int k = 0; k < 16; k++) begin
      lfsr_state = lfsr(lfsr_state);
      fetch({18'h0_0080, lfsr_state[11:0], 2'b00});
    end
    idle(40);
    check("pending", 34'(exp_instr.size()), 34'h0);
    $display("test random done");
    results();
  end
endmodule
